// ### bench/acm_bridge_model.sv
// Bridge switches and analog front end seen from the mode control block.
// Assumes gpio_out bits 0/1 drive the two bridge legs, one clock domain.
`timescale 1ns/100ps
module acm_bridge_model (
   input  wire logic        clk,
   input  wire logic        rev,
   input  wire logic [3:0]  gpio_out,
   input  wire logic        conv_start,
   input  wire logic [23:0] sig,
   input  wire logic [23:0] ofs,
   output logic [23:0]      raw_data,
   output int               overlaps,
   output int               toggles,
   output int               starts
);
   // Reversal flips the signal but never the front-end offset
   assign raw_data = rev ? ofs - sig : ofs + sig;

   logic phase_a_q;

   // Cross-conduction and switching-rate counters, judged by the bench
   always @(posedge clk) begin
      if (gpio_out[0] === 1'b1 && gpio_out[1] === 1'b1) overlaps++;
      if (gpio_out[0] === 1'b1 && phase_a_q !== 1'b1) toggles++;
      if (conv_start === 1'b1) starts++;
      phase_a_q <= gpio_out[0];
   end
endmodule // acm_bridge_model

// ### bench/acm_ctrl_tb_top.sv
// Self-checking bench for the conversion mode control block.
// Assumes a 25 MHz clock and a shortened power-on wait of 64 clocks.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
   begin \
      check_count++; \
      if ((ex) !== (gt)) begin \
         mismatches++; \
         $display("BAD %s exp %0h got %0h", nm, ex, gt); \
      end \
   end
module acm_ctrl_tb_top;
   import acm_pkg::*;
   typedef struct packed {logic [3:0] code; logic [1:0] mode; logic [3:0] sel;} acm_row_s;
   localparam int C = 40;
   localparam int POR = 64;
   logic              clk, rst_n, reset_pin_n, reset_cmd, start_pin, pd_n, ext_clk;
   logic              cfg_wr, flag_clr, ready, cstart, cinv, rinv, aen, ren, sen, fast;
   acm_cfg_s          cfg, cfg_r;
   acm_stat_s         stat;
   logic [23:0]       raw, res, sig, ofs, old;
   logic [3:0]        gpio, acsel, drv_seen;
   int                mismatches, check_count, cyc, overlaps, toggles, starts;
   int                k, ks, d;
   acm_row_s          rows [0:4] = '{'{4'h0, 2'h0, 4'h0}, '{4'h1, 2'h1, 4'h0},
                                     '{4'h2, 2'h2, 4'h3}, '{4'h2, 2'h3, 4'hF},
                                     '{4'h1, 2'h2, 4'h3}};

   acm_ctrl #(.POR_WAIT_CYC(POR)) dut_u (.clk(clk), .rst_n(rst_n),
      .reset_pin_n(reset_pin_n), .reset_cmd(reset_cmd), .start_pin(start_pin),
      .power_down_control(pd_n), .ext_clk_active(ext_clk), .cfg_wr(cfg_wr),
      .cfg_wdata(cfg), .flag_clr(flag_clr), .conv_cycles(26'(C)), .raw_data(raw),
      .cfg_rdata(cfg_r), .status(stat), .conversion_ready_out(ready), .result_data(res),
      .conv_start(cstart), .chop_invert(cinv), .ref_invert(rinv), .gpio_out(gpio),
      .gpio_ac_sel(acsel), .analog_enable(aen), .ref_enable(ren), .serial_enable(sen),
      .clk_fast_sel(fast));

   acm_bridge_model partner_u (.clk(clk), .rev(cinv | rinv), .gpio_out(gpio),
      .conv_start(cstart), .sig(sig), .ofs(ofs), .raw_data(raw), .overlaps(overlaps),
      .toggles(toggles), .starts(starts));

   // Clock and hang guard; the whole run needs about 19000 cycles
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         conclude();
      end
   end

   // Inputs change one small delay after each rising edge
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic wr_cfg();
      cfg_wr = 1'b1;
      tick(1);
      cfg_wr = 1'b0;
      tick(1);
   endtask
   task automatic pulse_clr();
      flag_clr = 1'b1;
      tick(1);
      flag_clr = 1'b0;
      tick(1);
   endtask
   task automatic wait_start();
      k = 0;
      while (cstart !== 1'b1 && k < 20000) begin
         tick(1);
         k++;
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence: power-on, table of modes, then power, clock and resets
   initial begin
      {rst_n, reset_pin_n, reset_cmd, cfg_wr, flag_clr, ext_clk} = 6'h10;
      {start_pin, pd_n} = 2'h3;
      cfg = CFG_RESET;
      sig = 24'h000123;
      ofs = 24'h000050;
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      k = 0;
      while (ready !== 1'b1 && k < 1000) begin
         tick(1);
         k++;
      end
      `CHK("por_wait", 1'b1, k >= POR - 1 && k <= POR)
      `CHK("por_flag", 1'b1, stat.reset_flag)
      `CHK("por_cfg", CFG_RESET, cfg_r)
      wait_start();
      `CHK("por_start", 1'b1, k >= 511 && k <= 512 + DELAY_UNIT_CYC + 1)
      pulse_clr();
      `CHK("flag_clear", 1'b0, stat.reset_flag)
      // Host gives AC rows delay code 2 or 1, both well over the filter settling
      for (int i = 0; i < 5; i++) begin
         start_pin = 1'b0;
         pd_n = 1'b0;
         cfg.delay_code = rows[i].code;
         cfg.polarity_mode = rows[i].mode;
         wr_cfg();
         `CHK("hw_pd_analog", 1'b0, aen)
         pd_n = 1'b1;
         sig = sig + 24'h000111; // Input only moves while stopped
         old = res;
         tick(1);
         start_pin = 1'b1;
         tick(1);
         d = (rows[i].code == 4'h0) ? 1 : int'(rows[i].code) * DELAY_UNIT_CYC;
         k = 0;
         ks = -1;
         while (res === old && k < 20000) begin
            if (cstart === 1'b1 && ks < 0) begin
               ks = k;
               drv_seen = gpio;
            end
            tick(1);
            k++;
         end
         `CHK("delay", d, ks)
         `CHK("latency", ((rows[i].mode != 2'h0) ? 2 : 1) * (d + C), k)
         `CHK("result", (rows[i].mode == 2'h0) ? ofs + sig : sig, res)
         `CHK("ac_sel", rows[i].sel, acsel)
         `CHK("drive_pins", rows[i].sel & 4'h5, drv_seen)
         if (rows[i].mode == 2'h3) `CHK("four_wire", gpio[1:0], gpio[3:2])
      end
      `CHK("overlap", 0, overlaps)
      `CHK("toggle_rate", 1'b1, toggles <= starts)
      cfg.ref_on = 1'b1;
      cfg.power_control_register[SW_PD_BIT] = 1'b1;
      wr_cfg();
      `CHK("sw_pd", 4'h7, {aen, sen, ren, stat.pd_active})
      pd_n = 1'b0;
      tick(2);
      `CHK("hw_pd", 2'h0, {aen, ren})
      `CHK("hw_pd_regs", cfg, cfg_r)
      pd_n = 1'b1;
      cfg.power_control_register[SW_PD_BIT] = 1'b0;
      cfg.rate_40k = 1'b1;
      ext_clk = 1'b1;
      wr_cfg();
      tick(1);
      `CHK("pd_exit", 1'b1, aen)
      `CHK("fast_clk", 1'b1, fast)
      `CHK("clk_src", 1'b1, stat.clk_src_ext)
      ext_clk = 1'b0;
      tick(2);
      `CHK("clk_src_int", 1'b0, stat.clk_src_ext)
      pulse_clr();
      reset_cmd = 1'b1;
      flag_clr = 1'b1;
      tick(1);
      {reset_cmd, flag_clr} = 2'h0;
      tick(1);
      `CHK("cmd_flag", 1'b1, stat.reset_flag)
      `CHK("cmd_cfg", CFG_RESET, cfg_r)
      pulse_clr();
      reset_pin_n = 1'b0;
      tick(1);
      reset_pin_n = 1'b1;
      tick(1);
      `CHK("pin_flag", 1'b1, stat.reset_flag)
      wait_start();
      `CHK("pin_start", 1'b1, k >= 510 && k <= 512 + DELAY_UNIT_CYC + 1)
      conclude();
   end
endmodule // acm_ctrl_tb_top

// ### logic/acm_ctrl.sv
// Conversion sequencing, chop and AC excitation, power-down and reset control.
// Assumes filter supplies raw_data when its conversion count runs out.
`timescale 1ns/100ps
module acm_ctrl #(
   parameter int POR_WAIT_CYC = acm_pkg::POR_WAIT_DEF
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     reset_pin_n,
   input  wire logic                     reset_cmd,
   input  wire logic                     start_pin,
   input  wire logic                     power_down_control,
   input  wire logic                     ext_clk_active,
   input  wire logic                     cfg_wr,
   input  acm_pkg::acm_cfg_s             cfg_wdata,
   input  wire logic                     flag_clr,
   input  wire logic [acm_pkg::CNT_W-1:0] conv_cycles,
   input  wire logic [23:0]              raw_data,
   output acm_pkg::acm_cfg_s             cfg_rdata,
   output acm_pkg::acm_stat_s            status,
   output logic                          conversion_ready_out,
   output logic [23:0]                   result_data,
   output logic                          conv_start,
   output logic                          chop_invert,
   output logic                          ref_invert,
   output logic [3:0]                    gpio_out,
   output logic [3:0]                    gpio_ac_sel,
   output logic                          analog_enable,
   output logic                          ref_enable,
   output logic                          serial_enable,
   output logic                          clk_fast_sel
);
   import acm_pkg::*;

   acm_state_e       state;
   acm_state_e       next_state;
   acm_cfg_s         cfg;
   logic [CNT_W-1:0] cnt;
   logic             start_q;
   logic             phase_rev;
   logic             have_prev;
   logic [23:0]      prev;
   logic             reset_flag;
   logic             clk_src_ext;
   logic             exc_a;
   logic             exc_b;

   // Reset sources and power state
   wire any_rst    = !rst_n || !reset_pin_n || reset_cmd;
   wire hw_pd      = !power_down_control;
   wire sw_pd      = cfg.power_control_register[SW_PD_BIT];
   wire pd         = hw_pd || sw_pd;
   wire start_rise = start_pin && !start_q;

   // Mode decode
   wire chop_on = cfg.polarity_mode == POL_CHOP;
   wire ac_mode = cfg.polarity_mode == POL_AC2 || cfg.polarity_mode == POL_AC4;
   wire ac4     = cfg.polarity_mode == POL_AC4;
   wire dual    = chop_on || ac_mode;

   // Stage lengths; start delay is code times 50 us
   wire [CNT_W-1:0] delay_cyc = CNT_W'(cfg.delay_code * DELAY_UNIT_CYC);
   wire [CNT_W-1:0] cnt_inc   = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
   wire por_end    = state == ST_POR && cnt == CNT_W'(POR_WAIT_CYC - 1);
   wire settle_end = state == ST_SETTLE && cnt == CNT_W'(START_WAIT_CYC - 1);
   wire delay_end  = state == ST_DELAY && cnt_inc >= delay_cyc;
   wire conv_end   = state == ST_CONV && cnt_inc >= conv_cycles;
   wire restart    = (state == ST_DELAY || state == ST_CONV) && !pd && start_rise;
   wire cdone      = conv_end && !pd && !start_rise;

   // A conversion begins when delay state is entered, or on a restart in delay or conversion state
   wire fresh_go   = (state == ST_SETTLE && settle_end && start_pin && !pd)
                  || (state == ST_IDLE && start_pin && !pd)
                  || restart;
   wire conv_begin = fresh_go || (cdone && start_pin);
   wire cnt_clr    = next_state != state || restart;

   // Chop arithmetic: reversed phase means previous minus current
   wire [24:0] cur_x  = {raw_data[23], raw_data};
   wire [24:0] prev_x = {prev[23], prev};
   wire [24:0] dsum   = phase_rev ? prev_x - cur_x : cur_x - prev_x;
   wire [23:0] half   = dsum[24:1];
   wire withhold      = dual && !have_prev;

   // Next state; power-down beats restart, restart beats completion
   always_comb begin
      next_state = state;
      case (state)
         ST_POR: begin
            if (por_end) next_state = ST_SETTLE;
         end
         ST_SETTLE: begin
            if (settle_end) next_state = (start_pin && !pd) ? ST_DELAY : ST_IDLE;
         end
         ST_IDLE: begin
            if (start_pin && !pd) next_state = ST_DELAY;
         end
         ST_DELAY: begin
            if (pd) next_state = ST_IDLE;
            else if (delay_end && !start_rise) next_state = ST_CONV;
         end
         ST_CONV: begin
            if (pd) next_state = ST_IDLE;
            else if (cdone) next_state = start_pin ? ST_DELAY : ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // State and stage counter
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= ST_POR;
         cnt   <= 26'h0;
      end else if (any_rst) begin
         state <= ST_SETTLE;
         cnt   <= 26'h0;
      end else begin
         state <= next_state;
         cnt   <= cnt_clr ? 26'h0 : cnt_inc;
      end
   end

   // Config held across power-down, reloaded only by reset
   always_ff @(posedge clk) begin
      if (any_rst) cfg <= CFG_RESET;
      else if (cfg_wr) cfg <= cfg_wdata;
   end

   // Sticky reset flag; a reset in the clear cycle wins
   always_ff @(posedge clk) begin
      if (any_rst) reset_flag <= 1'b1;
      else if (flag_clr) reset_flag <= 1'b0;
   end

   // Start edge and clock status
   always_ff @(posedge clk) begin
      if (any_rst) begin
         start_q      <= 1'b0;
         clk_src_ext  <= 1'b0;
         clk_fast_sel <= 1'b0;
      end else begin
         start_q      <= start_pin;
         clk_src_ext  <= ext_clk_active;
         clk_fast_sel <= cfg.rate_40k;
      end
   end

   // Chop phase and pipeline of the previous opposite-phase result
   always_ff @(posedge clk) begin
      if (any_rst || fresh_go || pd) begin
         phase_rev <= 1'b0;
         have_prev <= 1'b0;
         prev      <= 24'h0;
      end else if (cdone) begin
         phase_rev <= dual ? !phase_rev : 1'b0;
         have_prev <= dual;
         prev      <= raw_data;
      end
   end

   // Ready line: low through power-on wait, high at start, low at data if start pin is low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conversion_ready_out <= 1'b0;
         result_data          <= 24'h0;
         conv_start           <= 1'b0;
      end else if (any_rst) begin
         conversion_ready_out <= 1'b1;
         result_data          <= 24'h0;
         conv_start           <= 1'b0;
      end else begin
         conv_start <= delay_end && !pd && !start_rise;
         if (por_end || conv_begin) conversion_ready_out <= 1'b1;
         else if (cdone && !withhold) conversion_ready_out <= 1'b0;
         if (cdone && !withhold) result_data <= dual ? half : raw_data;
      end
   end

   // Excitation drives only while a conversion sequence runs in AC mode
   wire exc_en = ac_mode && !pd && (state == ST_DELAY || state == ST_CONV);

   acm_excite u_excite (
      .clk       (clk),
      .rst_n     (!any_rst),
      .enable    (exc_en),
      .phase_rev (phase_rev),
      .phase_a   (exc_a),
      .phase_b   (exc_b)
   );

   // Pin mapping; unused pins stay driven low, never floated
   assign gpio_out    = {ac4 && exc_b, ac4 && exc_a, exc_b, exc_a};
   assign gpio_ac_sel = !ac_mode ? 4'h0 : (ac4 ? 4'hF : 4'h3);
   assign chop_invert = chop_on && phase_rev;
   assign ref_invert  = ac_mode && phase_rev;

   // Power domains; soft power-down leaves reference bias alone
   assign analog_enable = !pd;
   assign ref_enable    = !hw_pd && cfg.ref_on;
   assign serial_enable = !hw_pd;

   assign cfg_rdata = cfg;
   assign status    = '{reset_flag: reset_flag, clk_src_ext: clk_src_ext, pd_active: pd};

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_POR_READY_LOW: assert property (
      state == ST_POR |-> !conversion_ready_out && cnt < CNT_W'(POR_WAIT_CYC))
      else $error("ready high during power-on wait");

   AST_POR_RELEASE: assert property (
      por_end && !any_rst |=> state == ST_SETTLE && conversion_ready_out)
      else $error("ready not raised after power-on wait");

   AST_START_AFTER_512: assert property (
      settle_end && start_pin && !pd && !any_rst |=> state == ST_DELAY && cnt == 26'h0)
      else $error("first conversion not begun after settle");

   AST_DELAY_LENGTH: assert property (
      state == ST_CONV && $past(state) == ST_DELAY |-> $past(cnt) + 26'h1 >= $past(delay_cyc))
      else $error("start delay cut short");

   AST_READY_AT_START: assert property (
      conv_begin && !any_rst |=> conversion_ready_out)
      else $error("ready not high at conversion start");

   AST_WITHHOLD_FIRST: assert property (
      cdone && withhold && !any_rst |=> $stable(result_data))
      else $error("first chop conversion not withheld");

   AST_CHOP_RESULT: assert property (
      cdone && dual && have_prev && !any_rst |=> result_data == $past(half)
         && (!conversion_ready_out || $past(start_pin)))
      else $error("chop result wrong");

   AST_PHASE_FLIP: assert property (
      cdone && dual && !any_rst && !pd |=> phase_rev != $past(phase_rev))
      else $error("chop phase did not reverse");

   AST_FLAG_SET: assert property (
      any_rst |=> status.reset_flag ##1 (status.reset_flag || $past(flag_clr)))
      else $error("reset flag not set");

   AST_HW_POWER_DOWN: assert property (
      hw_pd |-> !ref_enable && !analog_enable && !serial_enable)
      else $error("hardware power-down not applied");

   AST_FOUR_WIRE: assert property (
      !ac4 |-> gpio_out[3:2] == 2'h0)
      else $error("upper drives active outside four-wire mode");

endmodule // acm_ctrl

// ### logic/acm_excite.sv
// Non-overlapping bridge excitation driver.
// Assumes phase requests change at most once per conversion.
`timescale 1ns/100ps
module acm_excite (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic enable,
   input  wire logic phase_rev,
   output logic      phase_a,
   output logic      phase_b
);
   import acm_pkg::*;

   logic [1:0] drv;
   logic [2:0] gap;
   logic [1:0] want;

   // Requested drive pair {b, a}
   assign want = !enable ? 2'h0 : (phase_rev ? 2'h2 : 2'h1);
   assign phase_a = drv[0];
   assign phase_b = drv[1];

   // Break first, then wait the gap before making the new phase
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         drv <= 2'h0;
         gap <= 3'h0;
      end else if (drv != want && drv != 2'h0) begin
         drv <= 2'h0;
         gap <= 3'h0;
      end else if (drv != want) begin
         if (want == 2'h0 || gap == EXC_GAP_CYC - 3'h1) begin
            drv <= want;
         end else begin
            gap <= gap + 3'h1;
         end
      end
   end

   AST_NO_OVERLAP: assert property (@(posedge clk) disable iff (!rst_n)
      !(phase_a && phase_b)) else $error("excitation drives overlap");

   AST_GAP_AFTER_BREAK: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(phase_a) |-> !phase_b[*4]) else $error("no gap before phase b");

endmodule // acm_excite

// ### logic/acm_pkg.sv
// Constants, carrier structs and states for the conversion mode control block.
// Assumes a single 25 MHz clock and config bits written as plain ports.
//
// Operation
// - Each new conversion starts after a programmable delay; code 0001 gives 50 us; a start edge during conversion restarts it without the delay.
// - Start delay adds to conversion latency before data ready.
// - Chop mode reverses input polarity after the multiplexer every conversion.
// - Chop mode withholds first conversion, then outputs half the phase difference.
// - Chop output rate is one per latency; first result after twice the latency.
// - AC mode alternates bridge polarity, reverses reference, subtracts phase results.
// - Excitation drives never overlap; a gap separates each reversal.
// - Excitation drives toggle once per conversion, no faster.
// - Polarity mode 10 selects two-wire AC excitation, 11 four-wire.
// - Two-wire drives phases on GPIO0 and GPIO1; four-wire repeats them on GPIO2, GPIO3.
// - Converter clock 7.3728 MHz, except 10.24 MHz at 40000 SPS.
// - Clock source selected automatically and reported in a status bit.
// - Power-down pin low disables all but regulator and reference off; high wakes.
// - Power control bit 7 powers down core, keeps serial and reference bias.
// - Digital outputs stay driven in both power-down modes.
// - Any reset reinitialises serial, conversion control, filter and registers.
// - Every reset sets a sticky reset flag until the host clears it.
// - Start pin high when reset completes begins conversions without a command.
// - After power-on, ready output held low 2^16 clocks, then driven high.
// - First conversion begins 512 clocks after ready goes high, start pin high.
// - Ready output goes high at conversion start, low when the result is readable; stays high if start pin is high at completion.
package acm_pkg;

   // Timing
   localparam int CLK_PERIOD_NS  = 40;
   localparam int DELAY_UNIT_NS  = 50000;
   localparam int DELAY_UNIT_CYC = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_WAIT_DEF   = 65536;
   localparam int START_WAIT_CYC = 512;
   localparam logic [2:0] EXC_GAP_CYC = 3'h4;
   localparam int CNT_W          = 26;

   // Field codes and positions
   localparam logic [3:0] DELAY_DEFAULT = 4'h1;
   localparam logic [1:0] POL_OFF  = 2'h0;
   localparam logic [1:0] POL_CHOP = 2'h1;
   localparam logic [1:0] POL_AC2  = 2'h2;
   localparam logic [1:0] POL_AC4  = 2'h3;
   localparam int SW_PD_BIT = 7;

   typedef struct packed {
      logic [7:0] power_control_register;
      logic [1:0] polarity_mode;
      logic [3:0] delay_code;
      logic       rate_40k;
      logic       ref_on;
   } acm_cfg_s;

   typedef struct packed {
      logic reset_flag;
      logic clk_src_ext;
      logic pd_active;
   } acm_stat_s;

   localparam acm_cfg_s CFG_RESET = '{power_control_register: 8'h00,
                                      polarity_mode: POL_OFF,
                                      delay_code: DELAY_DEFAULT,
                                      rate_40k: 1'h0,
                                      ref_on: 1'h0};

   typedef enum logic [2:0] {ST_POR, ST_SETTLE, ST_IDLE, ST_DELAY, ST_CONV} acm_state_e;

endpackage
